// >>> inc/cpu_regs_pkg.sv
package cpu_regs_pkg;
	localparam logic [3:0] REG_PC = 4'h0;
	localparam logic [3:0] REG_SP = 4'h1;
	localparam logic [3:0] REG_SR = 4'h2;
	localparam logic [3:0] REG_CG = 4'h3;
	localparam int BIT_C = 0;
	localparam int BIT_Z = 1;
	localparam int BIT_N = 2;
	localparam int BIT_GIE = 3;
	localparam int BIT_PROCESSOR_HALT = 4;
	localparam int BIT_CRYSTAL_OSC_OFF = 5;
	localparam int BIT_CLOCK_GEN_ZERO_OFF = 6;
	localparam int BIT_CLOCK_GEN_ONE_OFF = 7;
	localparam int BIT_V = 8;
	localparam logic [15:0] SR_MASK = 16'h01ff;
	localparam logic [15:0] RESET_VALUE = 16'h0000;
	localparam logic [15:0] CONST_ZERO = 16'h0000;
	localparam logic [15:0] CONST_ONE = 16'h0001;
	localparam logic [15:0] CONST_TWO = 16'h0002;
	localparam logic [15:0] CONST_FOUR = 16'h0004;
	localparam logic [15:0] CONST_EIGHT = 16'h0008;
	localparam logic [15:0] CONST_MINUS = 16'hffff;
	localparam logic [1:0] MODE_REG = 2'h0;
	localparam logic [1:0] MODE_IDX = 2'h1;
	localparam logic [1:0] MODE_IND = 2'h2;
	localparam logic [1:0] MODE_INC = 2'h3;
	localparam logic [3:0] ALU_ADD = 4'h0;
	localparam logic [3:0] ALU_ADDC = 4'h1;
	localparam logic [3:0] ALU_SUB = 4'h2;
	localparam logic [3:0] ALU_SUBC = 4'h3;
	localparam logic [3:0] ALU_CMP = 4'h4;
	localparam logic [3:0] ALU_LOGIC = 4'h5;
	localparam logic [7:0] APB_SEL = 8'h00;
	localparam logic [7:0] APB_PC = 8'h40;
	localparam logic [7:0] APB_SP = 8'h44;
	localparam logic [7:0] APB_SR = 8'h48;
	localparam logic [7:0] APB_CTRL = 8'h4c;
endpackage : cpu_regs_pkg

// >>> core/flag_unit.sv
`timescale 1ns/1ps
module flag_unit (
	// Operation
	input wire logic [3:0] aluOp,
	input wire logic byteOp,
	input wire logic [15:0] srcVal,
	input wire logic [15:0] dstVal,
	input wire logic [16:0] sum,
	// Flags out
	output logic flagN,
	output logic flagZ,
	output logic flagC,
	output logic flagV
);
	logic sS;
	logic sD;
	logic sR;
	logic isAdd;
	logic isSub;
	always_comb begin
		sS = byteOp ? srcVal[7] : srcVal[15];
		sD = byteOp ? dstVal[7] : dstVal[15];
		sR = byteOp ? sum[7] : sum[15];
		isAdd = (aluOp == cpu_regs_pkg::ALU_ADD) || (aluOp == cpu_regs_pkg::ALU_ADDC);
		isSub = (aluOp == cpu_regs_pkg::ALU_SUB) || (aluOp == cpu_regs_pkg::ALU_SUBC)
			|| (aluOp == cpu_regs_pkg::ALU_CMP);
		flagN = sR;
		flagZ = byteOp ? (sum[7:0] == 8'h00) : (sum[15:0] == 16'h0000);
		flagC = byteOp ? sum[8] : sum[16];
		flagV = 1'b0;
		if (isAdd) begin
			flagV = (sS == sD) && (sR != sD);
		end else if (isSub) begin
			flagV = (sS != sD) && (sR != sD);
		end
	end
endmodule : flag_unit

// >>> core/const_source.sv
`timescale 1ns/1ps
module const_source (
	// Select
	input wire logic [3:0] srcReg,
	input wire logic [1:0] srcMode,
	// Result
	output logic isConst,
	output logic [15:0] constVal
);
	always_comb begin
		isConst = 1'b0;
		constVal = cpu_regs_pkg::CONST_ZERO;
		// No memory fetch needed for any of these
		if (srcReg == cpu_regs_pkg::REG_SR && srcMode != cpu_regs_pkg::MODE_REG) begin
			isConst = 1'b1;
			unique case (srcMode)
				cpu_regs_pkg::MODE_IDX: constVal = cpu_regs_pkg::CONST_ZERO;
				cpu_regs_pkg::MODE_IND: constVal = cpu_regs_pkg::CONST_FOUR;
				default: constVal = cpu_regs_pkg::CONST_EIGHT;
			endcase
		end else if (srcReg == cpu_regs_pkg::REG_CG) begin
			isConst = 1'b1;
			unique case (srcMode)
				cpu_regs_pkg::MODE_REG: constVal = cpu_regs_pkg::CONST_ZERO;
				cpu_regs_pkg::MODE_IDX: constVal = cpu_regs_pkg::CONST_ONE;
				cpu_regs_pkg::MODE_IND: constVal = cpu_regs_pkg::CONST_TWO;
				cpu_regs_pkg::MODE_INC: constVal = cpu_regs_pkg::CONST_MINUS;
			endcase
		end
	end
endmodule : const_source

// >>> core/cpu_special_register_file.sv
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module cpu_special_register_file (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Source read port
	input wire logic [3:0] srcReg,
	input wire logic [1:0] srcMode,
	output logic srcIsConst,
	output logic [15:0] srcData,
	// Destination read port
	input wire logic [3:0] dstReg,
	output logic [15:0] dstData,
	// Result write port
	input wire logic wrEn,
	input wire logic [3:0] wrReg,
	input wire logic wrByte,
	input wire logic [15:0] wrData,
	// Flag update from ALU
	input wire logic flagEn,
	input wire logic [3:0] aluOp,
	input wire logic [15:0] aluSrc,
	input wire logic [15:0] aluDst,
	input wire logic [16:0] aluSum,
	// Program counter advance
	input wire logic pcStep,
	input wire logic [1:0] instrWords,
	// Stack operations
	input wire logic pushEn,
	input wire logic popEn,
	input wire logic [15:0] popData,
	// Interrupt entry
	input wire logic irqEntry,
	// Clock status inputs
	input wire logic digOscUsed,
	input wire logic crystalUsed,
	// Control outputs
	output logic [15:0] programCounter,
	output logic [15:0] stackPointer,
	output logic [15:0] statusFlags,
	output logic processorHalt,
	output logic irqAccept,
	output logic dcGenOff,
	output logic loopCtrlOff,
	output logic crystalOscOff,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	logic [15:1] pcHi;
	logic [15:1] spHi;
	logic [8:0] sr;
	logic [15:0] work [4:15];
	logic [15:0] wrVal;
	logic [15:0] next_pc;
	logic [15:0] next_sp;
	logic [15:0] next_sr;
	logic flagN;
	logic flagZ;
	logic flagC;
	logic flagV;
	logic cIsConst;
	logic [15:0] cVal;
	logic apbWr;
	logic apbHit;

	flag_unit u_flags (
		.aluOp(aluOp),
		.byteOp(wrByte),
		.srcVal(aluSrc),
		.dstVal(aluDst),
		.sum(aluSum),
		.flagN(flagN),
		.flagZ(flagZ),
		.flagC(flagC),
		.flagV(flagV)
	);

	const_source u_const (
		.srcReg(srcReg),
		.srcMode(srcMode),
		.isConst(cIsConst),
		.constVal(cVal)
	);

	assign programCounter = {pcHi, 1'b0};
	assign stackPointer = {spHi, 1'b0};
	assign statusFlags = {7'h00, sr};
	assign wrVal = wrByte ? {8'h00, wrData[7:0]} : wrData;

	function automatic logic [15:0] readReg(input logic [3:0] idx);
		logic [15:0] v;
		v = cpu_regs_pkg::RESET_VALUE;
		if (idx == cpu_regs_pkg::REG_PC) begin
			v = programCounter;
		end else if (idx == cpu_regs_pkg::REG_SP) begin
			v = stackPointer;
		end else if (idx == cpu_regs_pkg::REG_SR) begin
			v = statusFlags;
		end else if (idx == cpu_regs_pkg::REG_CG) begin
			v = cpu_regs_pkg::CONST_ZERO;
		end else begin
			v = work[idx];
		end
		return v;
	endfunction : readReg

	assign srcIsConst = cIsConst;

	// Processes, not assigns: readReg looks at state beyond its argument
	always_comb begin
		srcData = readReg(srcReg);
		if (cIsConst) begin
			srcData = cVal;
		end
	end

	always_comb begin
		dstData = readReg(dstReg);
	end

	// APB: single-cycle access, no wait states
	assign apbWr = psel && penable && pwrite;
	assign apbHit = (paddr >= cpu_regs_pkg::APB_PC) && (paddr <= cpu_regs_pkg::APB_CTRL)
		&& (paddr[1:0] == 2'h0);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !apbHit;

	always_comb begin
		next_pc = programCounter;
		if (pcStep) begin
			next_pc = programCounter + {13'h0000, instrWords, 1'b0};
		end
		if (wrEn && wrReg == cpu_regs_pkg::REG_PC) begin
			next_pc = wrVal;
		end
		if (apbWr && paddr == cpu_regs_pkg::APB_PC) begin
			next_pc = pwdata[15:0];
		end
	end

	always_comb begin
		next_sp = stackPointer;
		if (pushEn) begin
			next_sp = stackPointer - 16'h0002;
		end else if (popEn) begin
			next_sp = stackPointer + 16'h0002;
		end
		if (wrEn && wrReg == cpu_regs_pkg::REG_SP) begin
			next_sp = wrVal;
		end
		if (apbWr && paddr == cpu_regs_pkg::APB_SP) begin
			next_sp = pwdata[15:0];
		end
	end

	always_comb begin
		next_sr = statusFlags;
		if (flagEn) begin
			next_sr[cpu_regs_pkg::BIT_N] = flagN;
			next_sr[cpu_regs_pkg::BIT_Z] = flagZ;
			next_sr[cpu_regs_pkg::BIT_C] = flagC;
			next_sr[cpu_regs_pkg::BIT_V] = flagV;
		end
		if (wrEn && wrReg == cpu_regs_pkg::REG_SR && !wrByte) begin
			next_sr = wrData & cpu_regs_pkg::SR_MASK;
		end
		if (apbWr && paddr == cpu_regs_pkg::APB_SR) begin
			next_sr = pwdata[15:0] & cpu_regs_pkg::SR_MASK;
		end
		if (irqEntry) begin
			next_sr[cpu_regs_pkg::BIT_PROCESSOR_HALT] = 1'b0;
			next_sr[cpu_regs_pkg::BIT_CLOCK_GEN_ONE_OFF] = 1'b0;
			next_sr[cpu_regs_pkg::BIT_CRYSTAL_OSC_OFF] = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pcHi <= 15'h0000;
		end else begin
			pcHi <= next_pc[15:1];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			spHi <= 15'h0000;
		end else begin
			spHi <= next_sp[15:1];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sr <= 9'h000;
		end else begin
			sr <= next_sr[8:0];
		end
	end

	// Register three has no storage, so writes naming it vanish
	genvar gi;
	generate
		for (gi = 4; gi < 16; gi++) begin : g_work
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					work[gi] <= cpu_regs_pkg::RESET_VALUE;
				end else if (wrEn && wrReg == 4'(gi)) begin
					work[gi] <= wrVal;
				end
			end
		end
	endgenerate

	assign processorHalt = sr[cpu_regs_pkg::BIT_PROCESSOR_HALT];
	assign irqAccept = sr[cpu_regs_pkg::BIT_GIE];
	assign dcGenOff = sr[cpu_regs_pkg::BIT_CLOCK_GEN_ONE_OFF] && !digOscUsed;
	assign loopCtrlOff = sr[cpu_regs_pkg::BIT_CLOCK_GEN_ZERO_OFF];
	assign crystalOscOff = sr[cpu_regs_pkg::BIT_CRYSTAL_OSC_OFF] && !crystalUsed;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				cpu_regs_pkg::APB_PC: prdata <= {16'h0000, programCounter};
				cpu_regs_pkg::APB_SP: prdata <= {16'h0000, stackPointer};
				cpu_regs_pkg::APB_SR: prdata <= {16'h0000, statusFlags};
				cpu_regs_pkg::APB_CTRL: prdata <= {27'h0000000, crystalOscOff, loopCtrlOff,
					dcGenOff, irqAccept, processorHalt};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// Pointer checks
	pc_even_a: assert property (@(posedge clk) disable iff (!rstn)
		programCounter[0] == 1'b0) else $error("pc odd");
	sp_even_a: assert property (@(posedge clk) disable iff (!rstn)
		stackPointer[0] == 1'b0) else $error("sp odd");
	pc_step_a: assert property (@(posedge clk) disable iff (!rstn)
		pcStep && !wrEn && !apbWr |=> programCounter == $past(programCounter)
		+ {13'h0000, $past(instrWords), 1'b0}) else $error("pc step wrong");
	pc_write_a: assert property (@(posedge clk) disable iff (!rstn)
		wrEn && wrReg == cpu_regs_pkg::REG_PC && !apbWr
		|=> programCounter == ($past(wrVal) & 16'hfffe)) else $error("pc write wrong");
	sp_push_a: assert property (@(posedge clk) disable iff (!rstn)
		pushEn && !wrEn && !apbWr |=> stackPointer == $past(stackPointer) - 16'h0002)
		else $error("push wrong");
	sp_pop_a: assert property (@(posedge clk) disable iff (!rstn)
		popEn && !pushEn && !wrEn && !apbWr |=> stackPointer == $past(stackPointer) + 16'h0002)
		else $error("pop wrong");
	sp_popself_a: assert property (@(posedge clk) disable iff (!rstn)
		popEn && wrEn && wrReg == cpu_regs_pkg::REG_SP && !apbWr
		|=> stackPointer == ($past(wrVal) & 16'hfffe)) else $error("pop sp wrong");
	sp_align_a: assert property (@(posedge clk) disable iff (!rstn)
		apbWr && paddr == cpu_regs_pkg::APB_SP
		|=> stackPointer == ($past(pwdata[15:0]) & 16'hfffe)) else $error("sp align wrong");

	// Low-power and interrupt control
	irq_clear_a: assert property (@(posedge clk) disable iff (!rstn)
		irqEntry |=> !processorHalt && !sr[cpu_regs_pkg::BIT_CLOCK_GEN_ONE_OFF]
		&& !sr[cpu_regs_pkg::BIT_CRYSTAL_OSC_OFF]) else $error("irq entry no clear");
	halt_keep_a: assert property (@(posedge clk) disable iff (!rstn)
		processorHalt && !irqEntry && !wrEn && !apbWr |=> processorHalt)
		else $error("halt dropped");
	irq_gate_a: assert property (@(posedge clk) disable iff (!rstn)
		irqAccept == statusFlags[cpu_regs_pkg::BIT_GIE]) else $error("irq gate wrong");
	loop_ctrl_a: assert property (@(posedge clk) disable iff (!rstn)
		loopCtrlOff == statusFlags[cpu_regs_pkg::BIT_CLOCK_GEN_ZERO_OFF]) else $error("loop ctrl wrong");
	dc_gen_a: assert property (@(posedge clk) disable iff (!rstn)
		digOscUsed |-> !dcGenOff) else $error("dc gen off while used");
	dc_gen_on_a: assert property (@(posedge clk) disable iff (!rstn)
		statusFlags[cpu_regs_pkg::BIT_CLOCK_GEN_ONE_OFF] && !digOscUsed |-> dcGenOff)
		else $error("dc gen not off");
	crystal_off_a: assert property (@(posedge clk) disable iff (!rstn)
		crystalOscOff |-> sr[cpu_regs_pkg::BIT_CRYSTAL_OSC_OFF] && !crystalUsed)
		else $error("crystal off wrong");
	crystal_on_a: assert property (@(posedge clk) disable iff (!rstn)
		statusFlags[cpu_regs_pkg::BIT_CRYSTAL_OSC_OFF] && !crystalUsed |-> crystalOscOff)
		else $error("crystal not off");

	// Flag checks are word-only so the expectations stay short
	flag_neg_a: assert property (@(posedge clk) disable iff (!rstn)
		flagEn && !wrByte && !wrEn && !apbWr
		|=> statusFlags[cpu_regs_pkg::BIT_N] == $past(aluSum[15]))
		else $error("negative flag wrong");
	flag_zero_a: assert property (@(posedge clk) disable iff (!rstn)
		flagEn && !wrByte && !wrEn && !apbWr
		|=> statusFlags[cpu_regs_pkg::BIT_Z] == ($past(aluSum[15:0]) == 16'h0000))
		else $error("zero flag wrong");
	flag_carry_a: assert property (@(posedge clk) disable iff (!rstn)
		flagEn && !wrByte && !wrEn && !apbWr
		|=> statusFlags[cpu_regs_pkg::BIT_C] == $past(aluSum[16]))
		else $error("carry flag wrong");
	add_ovf_a: assert property (@(posedge clk) disable iff (!rstn)
		flagEn && !wrByte && !wrEn && !apbWr && aluOp == cpu_regs_pkg::ALU_ADD
		&& aluSrc[15] == aluDst[15] && aluSum[15] != aluDst[15]
		|=> statusFlags[cpu_regs_pkg::BIT_V]) else $error("add overflow missed");
	sub_ovf_a: assert property (@(posedge clk) disable iff (!rstn)
		flagEn && !wrByte && !wrEn && !apbWr && aluOp == cpu_regs_pkg::ALU_SUB
		&& aluSrc[15] != aluDst[15] && aluSum[15] != aluDst[15]
		|=> statusFlags[cpu_regs_pkg::BIT_V]) else $error("sub overflow missed");
	byte_write_a: assert property (@(posedge clk) disable iff (!rstn)
		wrEn && wrByte && wrReg == 4'h4 |=> work[4][15:8] == 8'h00)
		else $error("byte write high");

	// Constant sources
	sr_operand_a: assert property (@(posedge clk) disable iff (!rstn)
		srcReg == cpu_regs_pkg::REG_SR && srcMode == cpu_regs_pkg::MODE_REG
		|-> !srcIsConst && srcData == statusFlags) else $error("sr operand wrong");
	sr_absolute_a: assert property (@(posedge clk) disable iff (!rstn)
		srcReg == cpu_regs_pkg::REG_SR && srcMode == cpu_regs_pkg::MODE_IDX
		|-> srcData == cpu_regs_pkg::CONST_ZERO) else $error("absolute base wrong");
	sr_four_a: assert property (@(posedge clk) disable iff (!rstn)
		srcReg == cpu_regs_pkg::REG_SR && srcMode == cpu_regs_pkg::MODE_IND
		|-> srcData == cpu_regs_pkg::CONST_FOUR) else $error("const four wrong");
	sr_eight_a: assert property (@(posedge clk) disable iff (!rstn)
		srcReg == cpu_regs_pkg::REG_SR && srcMode == cpu_regs_pkg::MODE_INC
		|-> srcData == cpu_regs_pkg::CONST_EIGHT) else $error("const eight wrong");
	cg_zero_a: assert property (@(posedge clk) disable iff (!rstn)
		srcReg == cpu_regs_pkg::REG_CG && srcMode == cpu_regs_pkg::MODE_REG
		|-> srcData == cpu_regs_pkg::CONST_ZERO) else $error("const zero wrong");
	cg_one_a: assert property (@(posedge clk) disable iff (!rstn)
		srcReg == cpu_regs_pkg::REG_CG && srcMode == cpu_regs_pkg::MODE_IDX
		|-> srcData == cpu_regs_pkg::CONST_ONE) else $error("const one wrong");
	cg_two_a: assert property (@(posedge clk) disable iff (!rstn)
		srcReg == cpu_regs_pkg::REG_CG && srcMode == cpu_regs_pkg::MODE_IND
		|-> srcData == cpu_regs_pkg::CONST_TWO) else $error("const two wrong");
	const_src_a: assert property (@(posedge clk) disable iff (!rstn)
		srcReg == cpu_regs_pkg::REG_CG && srcMode == cpu_regs_pkg::MODE_INC
		|-> srcData == 16'hffff) else $error("const wrong");
	cg_source_a: assert property (@(posedge clk) disable iff (!rstn)
		srcReg == cpu_regs_pkg::REG_CG |-> srcIsConst) else $error("constant not flagged");
endmodule : cpu_special_register_file

// >>> testbench/alu_model.sv
`timescale 1ns/1ps
module alu_model (
	// Operation
	input wire logic [3:0] aluOp,
	input wire logic carryIn,
	input wire logic [15:0] aluSrc,
	input wire logic [15:0] aluDst,
	// Adder result with carry out
	output logic [16:0] aluSum
);
	logic isSub;
	logic cin;
	// Subtract is dst plus inverted src plus one (plus carry instead of one for SUBC), as the flag logic expects
	assign isSub = (aluOp == cpu_regs_pkg::ALU_SUB) || (aluOp == cpu_regs_pkg::ALU_SUBC)
		|| (aluOp == cpu_regs_pkg::ALU_CMP);
	assign cin = (aluOp == cpu_regs_pkg::ALU_ADDC || aluOp == cpu_regs_pkg::ALU_SUBC) ? carryIn : isSub;
	assign aluSum = {1'b0, aluDst} + {1'b0, isSub ? ~aluSrc : aluSrc} + {16'h0000, cin};
endmodule : alu_model

// >>> testbench/cpu_special_register_file_tb_top.sv
`timescale 1ns/1ps
module cpu_special_register_file_tb_top;
	logic clk = 1'b0, rstn = 1'b0, srcIsConst, pready, pslverr, psel = 1'b0, penable = 1'b0;
	logic wrEn = 1'b0, wrByte = 1'b0, flagEn = 1'b0, pcStep = 1'b0, pushEn = 1'b0;
	logic popEn = 1'b0, irqEntry = 1'b0, digOscUsed = 1'b0, crystalUsed = 1'b0, pwrite = 1'b0;
	logic processorHalt, irqAccept, dcGenOff, loopCtrlOff, crystalOscOff;
	logic [3:0] srcReg = 4'h0, dstReg = 4'h4, wrReg = 4'h0, aluOp = 4'h0;
	logic [1:0] srcMode = 2'h0, instrWords = 2'h1;
	logic [15:0] srcData, dstData, wrData = 16'h0000, aluSrc = 16'h0000, aluDst = 16'h0000;
	logic [15:0] popData = 16'h0000, programCounter, stackPointer, statusFlags, d, pcExp;
	logic [16:0] aluSum;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata;
	logic [31:0] q[$];
	logic [51:0] ft [5] = '{52'h0_0001_7fff_0104, 52'h2_0001_8000_0101, 52'h1_0000_ffff_0003,
		52'h4_0002_0001_0004, 52'h3_fffe_7fff_0104};
	logic [23:0] ct [7] = '{24'h21_0000, 24'h22_0004, 24'h23_0008, 24'h30_0000, 24'h31_0001,
		24'h32_0002, 24'h33_ffff};
	int failures = 0, cmpCount = 0;

	initial begin
		forever #4 clk = ~clk;
	end

	cpu_special_register_file dut (.clk(clk), .rstn(rstn), .srcReg(srcReg), .srcMode(srcMode),
		.srcIsConst(srcIsConst), .srcData(srcData), .dstReg(dstReg), .dstData(dstData),
		.wrEn(wrEn), .wrReg(wrReg), .wrByte(wrByte), .wrData(wrData), .flagEn(flagEn),
		.aluOp(aluOp), .aluSrc(aluSrc), .aluDst(aluDst), .aluSum(aluSum), .pcStep(pcStep),
		.instrWords(instrWords), .pushEn(pushEn), .popEn(popEn), .popData(popData),
		.irqEntry(irqEntry), .digOscUsed(digOscUsed), .crystalUsed(crystalUsed),
		.programCounter(programCounter), .stackPointer(stackPointer),
		.statusFlags(statusFlags), .processorHalt(processorHalt), .irqAccept(irqAccept),
		.dcGenOff(dcGenOff), .loopCtrlOff(loopCtrlOff), .crystalOscOff(crystalOscOff),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	alu_model alu (.aluOp(aluOp), .carryIn(statusFlags[cpu_regs_pkg::BIT_C]),
		.aluSrc(aluSrc), .aluDst(aluDst), .aluSum(aluSum));

	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		cmpCount++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmpCount, failures);
		if (failures == 0 && cmpCount > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude

	// Master holds the request until pready is seen high with penable
	task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] v, input logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {16'h0000, v};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) failures++;
		chk({31'h0, e}, {31'h0, pslverr});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		q.push_back({16'h0000, exp});
		apb(1'b0, a, 16'h0000, 1'b0);
	endtask : rd

	// One datapath cycle: s = {step, push, pop}
	task automatic dp(input logic w, input logic [3:0] r, input logic b, input logic [15:0] v,
			input logic [2:0] s, input logic [1:0] iw);
		@(posedge clk);
		wrEn <= w;
		wrReg <= r;
		wrByte <= b;
		wrData <= v;
		pcStep <= s[2];
		pushEn <= s[1];
		popEn <= s[0];
		instrWords <= iw;
		popData <= ~v;
		@(posedge clk);
		wrEn <= 1'b0;
		pcStep <= 1'b0;
		pushEn <= 1'b0;
		popEn <= 1'b0;
	endtask : dp

	always @(posedge clk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0
				&& pslverr === 1'b0 && q.size() > 0) begin
			chk(q.pop_front(), prdata);
		end
	end

	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		conclude();
	end

	initial begin
		void'($urandom(25));
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rd(cpu_regs_pkg::APB_PC, 16'h0000);
		rd(cpu_regs_pkg::APB_SR, 16'h0000);
		apb(1'b0, 8'h50, 16'h0000, 1'b1);
		d = 16'($urandom()) | 16'h0001;
		dp(1'b1, cpu_regs_pkg::REG_PC, 1'b0, d, 3'b000, 2'h1);
		pcExp = d & 16'hfffe;
		rd(cpu_regs_pkg::APB_PC, pcExp);
		for (int w = 1; w <= 3; w++) begin
			dp(1'b0, 4'h4, 1'b0, 16'h0000, 3'b100, 2'(w));
			pcExp = pcExp + 16'(2 * w);
			rd(cpu_regs_pkg::APB_PC, pcExp);
		end
		@(negedge clk);
		chk({31'h0, pcExp[0]}, {31'h0, programCounter[0]});
		apb(1'b1, cpu_regs_pkg::APB_SP, 16'h0101, 1'b0);
		rd(cpu_regs_pkg::APB_SP, 16'h0100);
		dp(1'b0, 4'h4, 1'b0, 16'h0000, 3'b010, 2'h1);
		rd(cpu_regs_pkg::APB_SP, 16'h00fe);
		dp(1'b0, 4'h4, 1'b0, 16'h0000, 3'b001, 2'h1);
		rd(cpu_regs_pkg::APB_SP, 16'h0100);
		dp(1'b1, cpu_regs_pkg::REG_SP, 1'b0, 16'h1235, 3'b001, 2'h1);
		rd(cpu_regs_pkg::APB_SP, 16'h1234);
		d = 16'($urandom());
		dp(1'b1, 4'h4, 1'b0, d, 3'b000, 2'h1);
		@(negedge clk);
		chk({16'h0, d}, {16'h0, dstData});
		dp(1'b1, 4'h4, 1'b1, 16'habcd, 3'b000, 2'h1);
		@(negedge clk);
		chk(32'h00cd, {16'h0, dstData});
		dp(1'b1, cpu_regs_pkg::REG_CG, 1'b0, 16'h5555, 3'b000, 2'h1);
		// Includes the discarded write to the constant register above
		foreach (ct[i]) begin
			@(posedge clk);
			srcReg <= ct[i][23:20];
			srcMode <= ct[i][17:16];
			@(negedge clk);
			chk(32'h1, {31'h0, srcIsConst});
			chk({16'h0, ct[i][15:0]}, {16'h0, srcData});
		end
		foreach (ft[i]) begin
			@(posedge clk);
			flagEn <= 1'b1;
			aluOp <= ft[i][51:48];
			aluSrc <= ft[i][47:32];
			aluDst <= ft[i][31:16];
			@(posedge clk);
			flagEn <= 1'b0;
			rd(cpu_regs_pkg::APB_SR, ft[i][15:0]);
		end
		@(posedge clk);
		srcMode <= cpu_regs_pkg::MODE_REG;
		srcReg <= cpu_regs_pkg::REG_SR;
		@(negedge clk);
		chk({31'h0, srcIsConst}, 32'h0);
		chk({16'h0, ft[4][15:0]}, {16'h0, srcData});
		apb(1'b1, cpu_regs_pkg::APB_SR, 16'h00f8, 1'b0);
		rd(cpu_regs_pkg::APB_CTRL, 16'h001f);
		@(posedge clk);
		digOscUsed <= 1'b1;
		crystalUsed <= 1'b1;
		@(negedge clk);
		chk(32'h0b, {crystalOscOff, loopCtrlOff, dcGenOff, irqAccept, processorHalt});
		@(posedge clk);
		irqEntry <= 1'b1;
		@(posedge clk);
		irqEntry <= 1'b0;
		rd(cpu_regs_pkg::APB_SR, 16'h0048);
		@(negedge clk);
		chk(32'h0a, {crystalOscOff, loopCtrlOff, dcGenOff, irqAccept, processorHalt});
		conclude();
	end
endmodule : cpu_special_register_file_tb_top
